/* shared/ier_pkg.sv */
// Package for the interrupt enable register one block.
// Assumes a 32-bit AXI4-Lite register bus and a single clock domain.
package ier_pkg;

  // Register map: chosen offsets, byte addresses
  localparam logic [11:0] ENABLE_ONE_OFFSET = 12'h000;
  localparam logic [11:0] REQ_STATUS_OFFSET = 12'h004;
  localparam logic [11:0] GATED_OFFSET = 12'h008;
  localparam int ADDR_WIDTH = 12;
  localparam int DATA_WIDTH = 32;
  localparam int REG_WIDTH = 16;

  // Field positions of interrupt_enable_one
  localparam int UART_B_TX_BIT = 15;
  localparam int UART_B_RX_BIT = 14;
  localparam int EXT_TWO_BIT = 13;
  localparam int TIMER_FIVE_BIT = 12;
  localparam int TIMER_FOUR_BIT = 11;
  localparam int OC_FOUR_BIT = 10;
  localparam int OC_THREE_BIT = 9;
  localparam int UNUSED_EIGHT_BIT = 8;
  localparam int IC_EIGHT_BIT = 7;
  localparam int IC_SEVEN_BIT = 6;
  localparam int UNUSED_FIVE_BIT = 5;
  localparam int EXT_ONE_BIT = 4;
  localparam int CHANGE_BIT = 3;
  localparam int COMPARATOR_BIT = 2;
  localparam int I2C_MASTER_BIT = 1;
  localparam int I2C_SLAVE_BIT = 0;

  // Writable bits: all but 8 and 5
  localparam logic [15:0] ENABLE_ONE_MASK = 16'hFEDF;
  localparam logic [15:0] ENABLE_ONE_RESET = 16'h0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } ier_rdata_s;

endpackage : ier_pkg

/* verilog/ier_top.sv */
// Interrupt enable register one with an AXI4-Lite slave.
// Assumes requests from sources are synchronous to CLOCK and active high.
// Contract
// - An enable bit at one passes its source request, at zero blocks it.
// - Bit 15 is the read/write enable of the second UART transmitter.
// - Bit 14 is the read/write enable of the second UART receiver.
// - Bit 13 is the read/write enable of external interrupt two.
// - Bit 12 is the read/write enable of timer five.
// - Bit 11 is the read/write enable of timer four.
// - Bit 10 is the read/write enable of output compare four.
// - Bit 9 is the read/write enable of output compare three.
// - Bit 8 is unimplemented, reads zero and ignores writes.
// - Bit 7 is the read/write enable of input capture eight.
// - Bit 6 is the read/write enable of input capture seven.
// - Bit 3 is the read/write enable of input change notification.
// - Bit 2 is the read/write enable of the comparator.
// - Bits 1 and 0 enable the first I2C master and slave events.
`timescale 1ns/1ps
`default_nettype none

module ier_top
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // AXI4-Lite write address
  input wire logic [ier_pkg::ADDR_WIDTH-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic AWVALID,
  output logic AWREADY,
  // AXI4-Lite write data
  input wire logic [ier_pkg::DATA_WIDTH-1:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read address
  input wire logic [ier_pkg::ADDR_WIDTH-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  input wire logic ARVALID,
  output logic ARREADY,
  // AXI4-Lite read data
  output logic [ier_pkg::DATA_WIDTH-1:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Raw source requests, bit order as the enable register
  input wire logic [ier_pkg::REG_WIDTH-1:0] SRC_REQ,
  // Gated requests to the priority logic
  output logic [ier_pkg::REG_WIDTH-1:0] IRQ_REQ,
  // Enable bits for the consumer
  output logic [ier_pkg::REG_WIDTH-1:0] IRQ_ENABLE
);

  logic [15:0] enable_one_reg;
  logic [15:0] enable_one_next;
  logic [15:0] irq_req_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [ier_pkg::ADDR_WIDTH-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  ier_pkg::ier_rdata_s rd_reg;
  ier_pkg::ier_rdata_s rd_next;
  logic wr_fire;
  logic wr_hit;
  logic [15:0] wr_bits;
  logic [15:0] enable_view;
  // One named enable per implemented source
  logic uart_b_tx_irq_en;
  logic uart_b_rx_irq_en;
  logic ext_irq_two_en;
  logic timer_five_irq_en;
  logic timer_four_irq_en;
  logic out_compare_four_irq_en;
  logic out_compare_three_irq_en;
  logic in_capture_eight_irq_en;
  logic in_capture_seven_irq_en;
  logic ext_irq_one_en;
  logic change_notify_irq_en;
  logic comparator_irq_en;
  logic i2c_a_master_irq_en;
  logic i2c_a_slave_irq_en;

  // One write at a time: address and data are latched in any order
  assign AWREADY = !aw_hold_reg && !bvalid_reg;
  assign WREADY = !w_hold_reg && !bvalid_reg;
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_hit = awaddr_reg[ier_pkg::ADDR_WIDTH-1:2] ==
                  ier_pkg::ENABLE_ONE_OFFSET[ier_pkg::ADDR_WIDTH-1:2];

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= '0;
    end
    else if (AWVALID && AWREADY)
    begin
      aw_hold_reg <= 1'b1;
      awaddr_reg <= AWADDR;
    end
    else if (wr_fire)
    begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      w_hold_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end
    else if (WVALID && WREADY)
    begin
      w_hold_reg <= 1'b1;
      wdata_reg <= WDATA;
      wstrb_reg <= WSTRB;
    end
    else if (wr_fire)
    begin
      w_hold_reg <= 1'b0;
    end
  end

  // Byte lanes 0 and 1 carry the 16-bit register; upper lanes are ignored
  always_comb
  begin
    wr_bits = enable_one_reg;
    if (wstrb_reg[0])
    begin
      wr_bits[7:0] = wdata_reg[7:0];
    end
    if (wstrb_reg[1])
    begin
      wr_bits[15:8] = wdata_reg[15:8];
    end
    enable_one_next = enable_one_reg;
    if (wr_fire && wr_hit)
    begin
      // Unimplemented bits 8 and 5 never store a one
      enable_one_next = wr_bits & ier_pkg::ENABLE_ONE_MASK;
    end
  end

  // Bits 15..9, 7, 6, 4..0 are plain read/write flops
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      enable_one_reg <= ier_pkg::ENABLE_ONE_RESET;
    end
    else
    begin
      enable_one_reg <= enable_one_next;
    end
  end

  // Named taps of the stored enables
  assign uart_b_tx_irq_en =
    enable_one_reg[ier_pkg::UART_B_TX_BIT];
  assign uart_b_rx_irq_en =
    enable_one_reg[ier_pkg::UART_B_RX_BIT];
  assign ext_irq_two_en =
    enable_one_reg[ier_pkg::EXT_TWO_BIT];
  assign timer_five_irq_en =
    enable_one_reg[ier_pkg::TIMER_FIVE_BIT];
  assign timer_four_irq_en =
    enable_one_reg[ier_pkg::TIMER_FOUR_BIT];
  assign out_compare_four_irq_en =
    enable_one_reg[ier_pkg::OC_FOUR_BIT];
  assign out_compare_three_irq_en =
    enable_one_reg[ier_pkg::OC_THREE_BIT];
  assign in_capture_eight_irq_en =
    enable_one_reg[ier_pkg::IC_EIGHT_BIT];
  assign in_capture_seven_irq_en =
    enable_one_reg[ier_pkg::IC_SEVEN_BIT];
  assign ext_irq_one_en =
    enable_one_reg[ier_pkg::EXT_ONE_BIT];
  assign change_notify_irq_en =
    enable_one_reg[ier_pkg::CHANGE_BIT];
  assign comparator_irq_en =
    enable_one_reg[ier_pkg::COMPARATOR_BIT];
  assign i2c_a_master_irq_en =
    enable_one_reg[ier_pkg::I2C_MASTER_BIT];
  assign i2c_a_slave_irq_en =
    enable_one_reg[ier_pkg::I2C_SLAVE_BIT];

  // Image rebuilt from the taps: positions 8 and 5 are forced to zero
  // here as well, whatever the flops behind them might hold
  always_comb
  begin
    enable_view = '0;
    enable_view[ier_pkg::UART_B_TX_BIT] = uart_b_tx_irq_en;
    enable_view[ier_pkg::UART_B_RX_BIT] = uart_b_rx_irq_en;
    enable_view[ier_pkg::EXT_TWO_BIT] = ext_irq_two_en;
    enable_view[ier_pkg::TIMER_FIVE_BIT] = timer_five_irq_en;
    enable_view[ier_pkg::TIMER_FOUR_BIT] = timer_four_irq_en;
    enable_view[ier_pkg::OC_FOUR_BIT] = out_compare_four_irq_en;
    enable_view[ier_pkg::OC_THREE_BIT] = out_compare_three_irq_en;
    enable_view[ier_pkg::IC_EIGHT_BIT] = in_capture_eight_irq_en;
    enable_view[ier_pkg::IC_SEVEN_BIT] = in_capture_seven_irq_en;
    enable_view[ier_pkg::EXT_ONE_BIT] = ext_irq_one_en;
    enable_view[ier_pkg::CHANGE_BIT] = change_notify_irq_en;
    enable_view[ier_pkg::COMPARATOR_BIT] = comparator_irq_en;
    enable_view[ier_pkg::I2C_MASTER_BIT] = i2c_a_master_irq_en;
    enable_view[ier_pkg::I2C_SLAVE_BIT] = i2c_a_slave_irq_en;
    enable_view[ier_pkg::UNUSED_EIGHT_BIT] = 1'h0;
    enable_view[ier_pkg::UNUSED_FIVE_BIT] = 1'h0;
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= ier_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? ier_pkg::RESP_OKAY : ier_pkg::RESP_SLVERR;
    end
    else if (BREADY)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  assign BVALID = bvalid_reg;
  assign BRESP = bresp_reg;

  // Read side
  assign ARREADY = !rvalid_reg;

  always_comb
  begin
    rd_next.data = '0;
    rd_next.resp = ier_pkg::RESP_OKAY;
    case (ARADDR[ier_pkg::ADDR_WIDTH-1:2])
      ier_pkg::ENABLE_ONE_OFFSET[ier_pkg::ADDR_WIDTH-1:2]:
        rd_next.data = {16'h0000, enable_view};
      ier_pkg::REQ_STATUS_OFFSET[ier_pkg::ADDR_WIDTH-1:2]:
        rd_next.data = {16'h0000, SRC_REQ & ier_pkg::ENABLE_ONE_MASK};
      ier_pkg::GATED_OFFSET[ier_pkg::ADDR_WIDTH-1:2]:
        rd_next.data = {16'h0000, irq_req_reg};
      default:
        rd_next.resp = ier_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rvalid_reg <= 1'b0;
      rd_reg <= '0;
    end
    else if (ARVALID && ARREADY)
    begin
      rvalid_reg <= 1'b1;
      rd_reg <= rd_next;
    end
    else if (RREADY)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  assign RVALID = rvalid_reg;
  assign RDATA = rd_reg.data;
  assign RRESP = rd_reg.resp;

  // A cleared enable blocks its source; registered to keep outputs clean
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      irq_req_reg <= '0;
    end
    else
    begin
      irq_req_reg <= SRC_REQ & enable_view;
    end
  end

  assign IRQ_REQ = irq_req_reg;
  assign IRQ_ENABLE = enable_view;

endmodule : ier_top

`default_nettype wire

/* tb/ier_top_sva.sv */
// Checker for ier_top, bound to its ports.
// Assumes one clock domain with RST_B async, active low.
`timescale 1ns/1ps
`default_nettype none
module ier_sva
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // Bus
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic [1:0] RRESP,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  // Requests and enables
  input wire logic [15:0] SRC_REQ,
  input wire logic [15:0] IRQ_REQ,
  input wire logic [15:0] IRQ_ENABLE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  a_gate_req: assert property (
    IRQ_REQ == $past(SRC_REQ & IRQ_ENABLE)) else $error("gating wrong");
  a_unused_zero: assert property (
    (IRQ_ENABLE & ~ier_pkg::ENABLE_ONE_MASK) == 16'h0000)
    else $error("unused bit set");
  a_en_by_write: assert property (
    !$stable(IRQ_ENABLE) |-> $rose(BVALID) && BRESP == 2'h0)
    else $error("enable changed without write");
  a_b_hold: assert property (
    BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("B dropped");
  a_r_hold: assert property (
    RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("R dropped");
  a_read_zero: assert property (
    RVALID |-> (RDATA & 32'hFFFF0120) == 32'h0) else $error("bad zero bits");
  a_read_ans: assert property (
    ARVALID && ARREADY |=> RVALID) else $error("no read answer");
  a_read_enable: assert property (
    ARVALID && ARREADY && ARADDR == 12'h000
    |=> RDATA[15:0] == $past(IRQ_ENABLE) && RRESP == 2'h0)
    else $error("read data wrong");
  c_write: cover property (BVALID && BREADY);
  c_read: cover property (RVALID && RREADY);
  c_gate: cover property (IRQ_REQ != 16'h0000);
endmodule : ier_sva
bind ier_top ier_sva i_ier_sva (.*);
`default_nettype wire

/* tb/test_ier_top.sv */
// Self-checking bench for ier_top over AXI4-Lite.
// Assumes registers at 0x000, 0x004 and 0x008; the master waits on answers.
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_enable_register_one;
  logic CLOCK = 1'h0, RST_B = 1'h0;
  logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
  logic [2:0] AWPROT = 3'h0, ARPROT = 3'h0;
  logic [31:0] WDATA = 32'h00000000, RDATA, rd, en, wd;
  logic [31:0] seed = 32'h00000033;
  logic [3:0] WSTRB = 4'hF, ws;
  logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
  logic ARVALID = 1'h0, RREADY = 1'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP, rsp;
  logic [15:0] SRC_REQ = 16'h0000, IRQ_REQ, IRQ_ENABLE;
  int fails = 0, num_checks = 0, cyc = 0;
  ier_top i_ier_top (.*);
  always #4 CLOCK = ~CLOCK;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t resp %h want %h", $time, got, exp);
    end
  endtask : cmp_resp
  // Byte lanes 0 and 1 merge into the old value, then the writable mask
  function automatic logic [31:0] exp_en(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {16'h0000, {8{s[1]}}, {8{s[0]}}};
    return ((old & ~m) | (d & m)) & ier_pkg::ENABLE_ONE_MASK;
  endfunction : exp_en
  // Ready is raised a cycle after address and data are taken, in the same cycle as the response rises
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit ta, tw, tb;
    {ta, tw, tb} = 3'h0;
    AWADDR <= a;
    WDATA <= d;
    {AWVALID, WVALID, BREADY} <= 3'h6;
    while (!tb)
    begin
      @(posedge CLOCK);
      if (BVALID && BREADY)
      begin
        tb = 1;
        rsp = BRESP;
      end
      else if (ta && tw) BREADY <= 1;
      if (AWREADY && !ta)
      begin
        ta = 1;
        AWVALID <= 0;
      end
      if (WREADY && !tw)
      begin
        tw = 1;
        WVALID <= 0;
      end
    end
  endtask : wr
  task automatic rd_t(input logic [11:0] a);
    bit ta, tr;
    {ta, tr} = 2'h0;
    ARADDR <= a;
    {ARVALID, RREADY} <= 2'h2;
    while (!tr)
    begin
      @(posedge CLOCK);
      if (RVALID && RREADY)
      begin
        tr = 1;
        rd = RDATA;
        rsp = RRESP;
      end
      else if (ta) RREADY <= 1;
      if (ARREADY && !ta)
      begin
        ta = 1;
        ARVALID <= 0;
      end
    end
  endtask : rd_t
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      complete_run;
    end
  end
  initial
  begin
    repeat (16) @(posedge CLOCK);
    RST_B <= 1'h1;
    @(posedge CLOCK);
    cmp(IRQ_ENABLE, 32'h0);
    rd_t(ier_pkg::ENABLE_ONE_OFFSET);
    cmp(rd, 32'h0);
    en = 32'h0;
    // Full-word writes first, then random byte-lane strobes
    for (int i = 0; i < 40; i++)
    begin
      seed = xs(seed);
      wd = (i == 0) ? 32'h0000FFFF : (i == 1) ? 32'h0 : seed;
      ws = (i < 20) ? 4'hF : seed[11:8];
      WSTRB <= ws;
      wr(ier_pkg::ENABLE_ONE_OFFSET, wd);
      cmp_resp(rsp, ier_pkg::RESP_OKAY);
      en = exp_en(en, wd, ws);
      SRC_REQ <= seed[31:16];
      rd_t(ier_pkg::ENABLE_ONE_OFFSET);
      cmp(rd, en);
      cmp(IRQ_ENABLE, en);
      rd_t(ier_pkg::GATED_OFFSET);
      cmp(rd, seed[31:16] & en);
      cmp(IRQ_REQ, seed[31:16] & en);
    end
    WSTRB <= 4'hF;
    wr(ier_pkg::REQ_STATUS_OFFSET, 32'h0000FFFF);
    cmp_resp(rsp, ier_pkg::RESP_SLVERR);
    rd_t(ier_pkg::ENABLE_ONE_OFFSET);
    cmp(rd, en);
    rd_t(ier_pkg::REQ_STATUS_OFFSET);
    cmp(rd, SRC_REQ & ier_pkg::ENABLE_ONE_MASK);
    rd_t(12'hFFC);
    cmp_resp(rsp, ier_pkg::RESP_SLVERR);
    cmp(rd, 32'h0);
    // A reset in mid-run must clear enables that were written
    wr(ier_pkg::ENABLE_ONE_OFFSET, 32'h0000FFFF);
    cmp(IRQ_ENABLE, ier_pkg::ENABLE_ONE_MASK);
    RST_B <= 1'h0;
    repeat (4) @(posedge CLOCK);
    cmp(IRQ_ENABLE, 32'h0);
    RST_B <= 1'h1;
    @(posedge CLOCK);
    rd_t(ier_pkg::ENABLE_ONE_OFFSET);
    cmp(rd, 32'h0);
    complete_run;
  end
endmodule : test_interrupt_enable_register_one
`default_nettype wire
